// ==== design/brc_reset_config.sv ====
// Board reset merging, reset configuration, abort interrupt and transceiver gating
`timescale 1ns/1ns
module brc_reset_config
#(
  parameter int unsigned POR_CYCLES      = brc_pkg::POR_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = brc_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned CS_REGIONS      = brc_pkg::CS_REGIONS
)
(
  // Clock and reset
  input  wire logic                          CLOCK,
  input  wire logic                          RESET,
  // Supply detector and buttons, all low when active
  input  wire logic                          VOLTAGE_LOW_N,
  input  wire logic                          POWER_ON_BUTTON_N,
  input  wire logic                          SOFT_RESET_BUTTON_N,
  input  wire logic                          ABORT_BUTTON_N,
  // Host reset through the command converter
  input  wire logic                          HOST_SERIAL_MODE,
  input  wire logic                          PARALLEL_DATA_BIT3,
  input  wire logic                          PARALLEL_INIT_N,
  // Debug-port controller configuration levels
  input  wire logic                          DEBUG_MODE_ENABLE,
  input  wire logic                          DEBUG_MODE_ENTRY,
  input  wire logic                          DEBUG_CLOCK_MODE,
  // Configuration word write and readback
  input  wire logic                          CONFIG_WRITE,
  input  wire logic [brc_pkg::CFG_WIDTH-1:0] CONFIG_WRITE_DATA,
  output logic      [brc_pkg::CFG_WIDTH-1:0] CONFIG_WORD,
  // Chip-select region enables and processor chip selects
  input  wire logic [CS_REGIONS-1:0]         REGION_ENABLE,
  input  wire logic [CS_REGIONS-1:0]         CHIP_SELECT_N,
  // Power-on reset and clock mode pins
  output logic                               POWER_ON_RESET_N,
  output logic [1:0]                         CLOCK_MODE_PINS,
  output logic                               CLOCK_MODE_OE,
  // Shared open-drain hard reset line
  input  wire logic                          HARD_RESET_N_IN,
  output logic                               HARD_RESET_N_OUT,
  output logic                               HARD_RESET_N_OE,
  // Shared open-drain soft reset line
  input  wire logic                          SOFT_RESET_N_IN,
  output logic                               SOFT_RESET_N_OUT,
  output logic                               SOFT_RESET_N_OE,
  // Hard reset configuration onto the data bus
  output logic                               RESET_CONFIG_SELECT_N,
  output logic [brc_pkg::CFG_WIDTH-1:0]      CONFIG_DATA,
  output logic                               CONFIG_DATA_OE,
  // Debug port configuration pins
  output logic                               DEBUG_SERIAL_CLOCK,
  output logic                               DEBUG_SERIAL_DATA_IN,
  output logic                               DEBUG_PINS_OE,
  // Shared open-drain interrupt line zero
  input  wire logic                          IRQ_LINE0_N_IN,
  output logic                               IRQ_LINE0_N_OUT,
  output logic                               IRQ_LINE0_N_OE,
  output logic                               NMI_SEEN,
  // Local data transceiver enable
  output logic                               TRANSCEIVER_ENABLE
);

  // Refused at elaboration: sizes the vectors and counters cannot serve
  if (CS_REGIONS < 1 || CS_REGIONS > 32)
    $error("brc_reset_config: CS_REGIONS out of range");
  if (POR_CYCLES < 1 || DEBOUNCE_CYCLES < 1)
    $error("brc_reset_config: timing counts must be at least 1");

  localparam int unsigned PIN_W = 6 + CS_REGIONS;
  localparam int unsigned SHOW_W = $clog2(brc_pkg::DEBUG_SHOW_CYCLES + 1);

  logic             pwr_button;
  logic             soft_button;
  logic             abort_button;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             volt_low;
  logic             host_bit3;
  logic             host_init_n;
  logic             hard_line_low;
  logic             soft_line_low;
  logic             irq_line_low;
  logic [CS_REGIONS-1:0] cs_active_n;

  logic             por_request;
  logic             por_active;
  logic             host_request;
  logic             hard_request;
  logic             hard_active;
  logic             soft_request;
  logic             soft_active;
  logic             hard_seen;
  logic             hard_seen_prev;
  logic             hard_entry;

  logic [brc_pkg::CFG_WIDTH-1:0] cfg_stored;
  logic [brc_pkg::CFG_WIDTH-1:0] cfg_drive;

  brc_pkg::brc_dbg_t             dbg_state;
  brc_pkg::brc_dbg_t             next_dbg_state;
  logic [SHOW_W-1:0]             show_count;
  logic                          hit_enabled;

  // Buttons are debounced so contact bounce cannot chatter the resets
  brc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_pwr_button
  (
    .clk      (CLOCK),
    .reset    (RESET),
    .button_n (POWER_ON_BUTTON_N),
    .pressed  (pwr_button)
  );

  brc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_soft_button
  (
    .clk      (CLOCK),
    .reset    (RESET),
    .button_n (SOFT_RESET_BUTTON_N),
    .pressed  (soft_button)
  );

  brc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_abort_button
  (
    .clk      (CLOCK),
    .reset    (RESET),
    .button_n (ABORT_BUTTON_N),
    .pressed  (abort_button)
  );

  // Remaining pins arrive from outside the clock domain
  assign pin_raw = {CHIP_SELECT_N, IRQ_LINE0_N_IN, SOFT_RESET_N_IN, HARD_RESET_N_IN,
                    PARALLEL_INIT_N, PARALLEL_DATA_BIT3, VOLTAGE_LOW_N};

  // Two-flop synchroniser; idle levels are the inactive ones
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pin_meta <= {{CS_REGIONS{1'b1}}, 6'h3D};
      pin_sync <= {{CS_REGIONS{1'b1}}, 6'h3D};
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign volt_low      = ~pin_sync[0];
  assign host_bit3     = pin_sync[1];
  assign host_init_n   = pin_sync[2];
  assign hard_line_low = ~pin_sync[3];
  assign soft_line_low = ~pin_sync[4];
  assign irq_line_low  = ~pin_sync[5];
  assign cs_active_n   = pin_sync[PIN_W-1:6];

  // Detector trip or button starts the long power-on hold
  assign por_request = volt_low | pwr_button;

  brc_hold_timer #(.HOLD_CYCLES(POR_CYCLES), .ACTIVE_RESET(1'b1)) u_por_hold
  (
    .clk     (CLOCK),
    .reset   (RESET),
    .request (por_request),
    .active  (por_active)
  );

  assign POWER_ON_RESET_N = ~por_active;

  // Mode pins stand during power-on reset, released afterwards
  assign CLOCK_MODE_PINS = brc_pkg::CLOCK_MODE_PLL;
  assign CLOCK_MODE_OE   = por_active;

  // Host reset request depends on the converter transfer mode
  assign host_request = HOST_SERIAL_MODE ? host_bit3 : ~host_init_n;

  // Both buttons together mean hard reset; power-on also implies it
  assign hard_request = (soft_button & abort_button) | host_request | por_active;
  assign soft_request = soft_button & ~abort_button;

  // Board assertion lasts at least as long as an internal source
  brc_hold_timer #(.HOLD_CYCLES(brc_pkg::RESET_HOLD_CYCLES)) u_hard_hold
  (
    .clk     (CLOCK),
    .reset   (RESET),
    .request (hard_request),
    .active  (hard_active)
  );

  brc_hold_timer #(.HOLD_CYCLES(brc_pkg::RESET_HOLD_CYCLES)) u_soft_hold
  (
    .clk     (CLOCK),
    .reset   (RESET),
    .request (soft_request),
    .active  (soft_active)
  );

  // Open drain only: drive low or let go, never drive high
  assign HARD_RESET_N_OUT = 1'b0;
  assign HARD_RESET_N_OE  = hard_active;
  assign SOFT_RESET_N_OUT = 1'b0;
  assign SOFT_RESET_N_OE  = soft_active;

  // Line level covers the processor's own sources as well
  assign hard_seen  = hard_line_low | hard_active;
  assign hard_entry = hard_seen & ~hard_seen_prev;

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      hard_seen_prev <= 1'b0;
    else
      hard_seen_prev <= hard_seen;
  end

  // Stored word: defaults at power-on, software may rewrite later
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      cfg_stored <= brc_pkg::CONFIG_DEFAULT;
    else if (por_active)
      cfg_stored <= brc_pkg::CONFIG_DEFAULT;
    else if (CONFIG_WRITE)
      cfg_stored <= CONFIG_WRITE_DATA;
  end

  assign CONFIG_WORD = cfg_stored;

  // Snapshot at hard reset entry so a rewrite waits for the next one
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      cfg_drive <= brc_pkg::CONFIG_DEFAULT;
    else if (por_active)
      cfg_drive <= brc_pkg::CONFIG_DEFAULT;
    else if (hard_entry)
      cfg_drive <= cfg_stored;
  end

  // Select stands for the whole hard reset, word from the cycle after entry, reserved bits as stored
  assign CONFIG_DATA           = cfg_drive;
  assign CONFIG_DATA_OE        = hard_seen & ~hard_entry;
  assign RESET_CONFIG_SELECT_N = ~hard_seen;

  // Debug presentation: held during soft reset, then the entry level on the serial clock pin for a window after release
  always_comb
  begin
    next_dbg_state = dbg_state;
    case (dbg_state)
      brc_pkg::BRC_DBG_IDLE:
        if (soft_line_low)
          next_dbg_state = brc_pkg::BRC_DBG_HELD;
      brc_pkg::BRC_DBG_HELD:
        if (!soft_line_low)
          next_dbg_state = brc_pkg::BRC_DBG_AFTER;
      brc_pkg::BRC_DBG_AFTER:
        if (soft_line_low)
          next_dbg_state = brc_pkg::BRC_DBG_HELD;
        else if (show_count == SHOW_W'(brc_pkg::DEBUG_SHOW_CYCLES - 1))
          next_dbg_state = brc_pkg::BRC_DBG_IDLE;
      default:
        next_dbg_state = brc_pkg::BRC_DBG_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      dbg_state <= brc_pkg::BRC_DBG_IDLE;
    else
      dbg_state <= next_dbg_state;
  end

  // Window after release counted from zero
  always_ff @(posedge CLOCK)
  begin
    if (RESET || dbg_state != brc_pkg::BRC_DBG_AFTER)
      show_count <= '0;
    else
      show_count <= show_count + SHOW_W'(1);
  end

  // Registered debug pins so they never glitch across the release
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      DEBUG_SERIAL_CLOCK   <= 1'b0;
      DEBUG_SERIAL_DATA_IN <= 1'b0;
      DEBUG_PINS_OE        <= 1'b0;
    end
    else
    begin
      DEBUG_PINS_OE <= (next_dbg_state != brc_pkg::BRC_DBG_IDLE);
      if (next_dbg_state == brc_pkg::BRC_DBG_HELD)
      begin
        DEBUG_SERIAL_CLOCK   <= DEBUG_MODE_ENABLE;
        DEBUG_SERIAL_DATA_IN <= DEBUG_CLOCK_MODE;
      end
      else
      begin
        DEBUG_SERIAL_CLOCK   <= DEBUG_MODE_ENTRY;
        DEBUG_SERIAL_DATA_IN <= DEBUG_CLOCK_MODE;
      end
    end
  end

  // Abort alone raises the interrupt; with soft reset it means hard reset
  assign IRQ_LINE0_N_OUT = 1'b0;
  assign IRQ_LINE0_N_OE  = abort_button & ~soft_button;
  assign NMI_SEEN        = irq_line_low;

  // Open only for enabled, selected regions or during configuration
  assign hit_enabled        = |(~cs_active_n & REGION_ENABLE);
  assign TRANSCEIVER_ENABLE = hit_enabled | CONFIG_DATA_OE;

endmodule // brc_reset_config

// ==== design/brc_pkg.sv ====
// Constants for the board reset and configuration block
package brc_pkg;

  // Clock rate and timing figures
  localparam int unsigned CLOCK_KHZ      = 125000;
  localparam int unsigned POR_TIME_MS    = 500;
  localparam int unsigned POR_CYCLES     = POR_TIME_MS * CLOCK_KHZ;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * CLOCK_KHZ;
  localparam int unsigned RESET_HOLD_CYCLES = 512;
  localparam int unsigned DEBUG_SHOW_NS  = 1000;
  localparam int unsigned DEBUG_SHOW_CYCLES = (DEBUG_SHOW_NS * CLOCK_KHZ) / 1000000;

  // Clock mode pattern during power-on reset
  localparam logic [1:0] CLOCK_MODE_PLL = 2'h2;

  // Configuration word width, lane n drives processor data bit n
  localparam int unsigned CFG_WIDTH = 16;

  // Field positions in the configuration word
  localparam int unsigned ARB_POS   = 0;
  localparam int unsigned PREFIX_POS = 1;
  localparam int unsigned BOOT_DIS_POS = 3;
  localparam int unsigned BOOT_PORT_POS = 4;
  localparam int unsigned SPACE_POS = 7;
  localparam int unsigned CARD_PIN_POS = 9;
  localparam int unsigned DBG_PIN_POS = 11;
  localparam int unsigned BUS_DIV_POS = 13;

  // Field values of the default word
  localparam logic [15:0] ARB_INTERNAL   = 16'h0000;
  localparam logic [15:0] PREFIX_ZERO    = 16'h0001;
  localparam logic [15:0] BOOT_ENABLED   = 16'h0000;
  localparam logic [15:0] BOOT_PORT_32   = 16'h0000;
  localparam logic [15:0] SPACE_DEFAULT  = 16'h0000;
  localparam logic [15:0] CARD_PINS_KEEP = 16'h0000;
  localparam logic [15:0] DBG_ON_SCAN    = 16'h0002;
  localparam logic [15:0] BUS_DIV_1TO1   = 16'h0000;

  localparam logic [15:0] CONFIG_DEFAULT =
    (ARB_INTERNAL << ARB_POS) | (PREFIX_ZERO << PREFIX_POS) |
    (BOOT_ENABLED << BOOT_DIS_POS) | (BOOT_PORT_32 << BOOT_PORT_POS) |
    (SPACE_DEFAULT << SPACE_POS) | (CARD_PINS_KEEP << CARD_PIN_POS) |
    (DBG_ON_SCAN << DBG_PIN_POS) | (BUS_DIV_1TO1 << BUS_DIV_POS);

  // Number of chip-select regions
  localparam int unsigned CS_REGIONS = 8;

  // Soft reset debug presentation phases
  typedef enum logic [1:0]
  {
    BRC_DBG_IDLE  = 2'b00,
    BRC_DBG_HELD  = 2'b01,
    BRC_DBG_AFTER = 2'b10
  } brc_dbg_t;

endpackage

// ==== design/brc_debounce.sv ====
// Two-flop synchroniser and debouncer for one active-low button
`timescale 1ns/1ns
module brc_debounce
#(
  parameter int unsigned STABLE_CYCLES = 1250000
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Raw button, low when pressed
  input  wire logic button_n,
  // Clean level, high while pressed
  output logic      pressed
);

  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

  // Refused at elaboration, a zero window never settles
  if (STABLE_CYCLES < 1)
    $error("brc_debounce: STABLE_CYCLES must be at least 1");

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] count;

  // Two flops before any logic looks at the pin
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end
    else
    begin
      sync_a <= button_n;
      sync_b <= sync_a;
    end
  end

  // Level must stand unchanged before it is taken
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count   <= '0;
      pressed <= 1'b0;
    end
    else if (~sync_b == pressed)
      count <= '0;
    else if (count == CW'(STABLE_CYCLES - 1))
    begin
      count   <= '0;
      pressed <= ~sync_b;
    end
    else
      count <= count + CW'(1);
  end

endmodule // brc_debounce

// ==== design/brc_hold_timer.sv ====
// Stretches a request level by a fixed number of cycles after it drops
`timescale 1ns/1ns
module brc_hold_timer
#(
  parameter int unsigned HOLD_CYCLES  = 512,
  parameter bit          ACTIVE_RESET = 1'b0
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Request level
  input  wire logic request,
  // High while requested and for HOLD_CYCLES afterwards
  output logic      active
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  // Refused at elaboration, a zero hold adds nothing
  if (HOLD_CYCLES < 1)
    $error("brc_hold_timer: HOLD_CYCLES must be at least 1");

  logic [CW-1:0] remain;

  // Reload while requested, count down afterwards
  always_ff @(posedge clk)
  begin
    if (reset)
      remain <= ACTIVE_RESET ? CW'(HOLD_CYCLES) : '0;
    else if (request)
      remain <= CW'(HOLD_CYCLES);
    else if (remain != '0)
      remain <= remain - CW'(1);
  end

  assign active = request | (remain != '0);

endmodule // brc_hold_timer

// ==== tb/brc_reset_config_sva.sv ====
// Port-level checks of the reset and configuration block
`timescale 1ns/1ns
module brc_reset_config_sva
#(
  parameter int unsigned POR_CYCLES = 50,
  parameter int unsigned CS_REGIONS = 8
)
(
  // Clock and reset
  input wire logic                  CLOCK,
  input wire logic                  RESET,
  // Reset lines
  input wire logic                  POWER_ON_RESET_N,
  input wire logic [1:0]            CLOCK_MODE_PINS,
  input wire logic                  CLOCK_MODE_OE,
  input wire logic                  HARD_RESET_N_OUT,
  input wire logic                  HARD_RESET_N_OE,
  input wire logic                  SOFT_RESET_N_OUT,
  input wire logic                  SOFT_RESET_N_OE,
  // Configuration and debug pins
  input wire logic                  RESET_CONFIG_SELECT_N,
  input wire logic [15:0]           CONFIG_WORD,
  input wire logic [15:0]           CONFIG_DATA,
  input wire logic                  CONFIG_DATA_OE,
  input wire logic                  DEBUG_MODE_ENABLE,
  input wire logic                  DEBUG_SERIAL_CLOCK,
  input wire logic                  DEBUG_PINS_OE,
  // Interrupt and transceivers
  input wire logic                  IRQ_LINE0_N_OUT,
  input wire logic                  IRQ_LINE0_N_OE,
  input wire logic                  NMI_SEEN,
  input wire logic [CS_REGIONS-1:0] REGION_ENABLE,
  input wire logic [CS_REGIONS-1:0] CHIP_SELECT_N,
  input wire logic                  TRANSCEIVER_ENABLE
);
  int unsigned por_low;
  int unsigned hard_high;
  wire         no_cs = &(CHIP_SELECT_N | ~REGION_ENABLE);

  // Length counters; reset restarts them so a release never looks short
  always_ff @(posedge CLOCK)
  begin
    por_low   <= (RESET || POWER_ON_RESET_N) ? 0 : por_low + 1;
    hard_high <= (RESET || !HARD_RESET_N_OE) ? 0 : hard_high + 1;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_mode_pattern: assert property (CLOCK_MODE_OE |-> CLOCK_MODE_PINS == 2'h2)
    else $error("clock mode pattern wrong");
  a_por_drives_all: assert property (!POWER_ON_RESET_N |-> CLOCK_MODE_OE && HARD_RESET_N_OE)
    else $error("power-on reset without mode or hard drive");
  a_por_long_enough: assert property ($rose(POWER_ON_RESET_N) |-> por_low >= POR_CYCLES - 1)
    else $error("power-on reset too short");
  a_hard_open_drain: assert property (HARD_RESET_N_OE |-> !HARD_RESET_N_OUT)
    else $error("hard line driven high");
  a_soft_open_drain: assert property (SOFT_RESET_N_OE |-> !SOFT_RESET_N_OUT)
    else $error("soft line driven high");
  a_irq_open_drain: assert property (IRQ_LINE0_N_OE |-> !IRQ_LINE0_N_OUT)
    else $error("interrupt line driven high");
  a_hard_cfg_select: assert property (HARD_RESET_N_OE |-> !RESET_CONFIG_SELECT_N)
    else $error("config select missing in hard reset");
  a_hard_hold_time: assert property ($fell(HARD_RESET_N_OE) |-> hard_high >= 511)
    else $error("hard reset pull too short");
  a_cfg_snapshot: assert property ($fell(RESET_CONFIG_SELECT_N) |=> CONFIG_DATA_OE &&
    CONFIG_DATA == ($past(POWER_ON_RESET_N) ? $past(CONFIG_WORD) : brc_pkg::CONFIG_DEFAULT))
    else $error("config word not driven on entry");
  a_xcvr_for_config: assert property (CONFIG_DATA_OE |-> TRANSCEIVER_ENABLE)
    else $error("transceivers closed during config");
  a_xcvr_closed: assert property (no_cs[*4] ##0 !CONFIG_DATA_OE |-> !TRANSCEIVER_ENABLE)
    else $error("transceivers open with no enabled select");
  a_nmi_raised: assert property (IRQ_LINE0_N_OE[*5] |-> NMI_SEEN)
    else $error("interrupt not seen");
  a_debug_enable: assert property ($rose(DEBUG_PINS_OE) |-> DEBUG_SERIAL_CLOCK == $past(DEBUG_MODE_ENABLE))
    else $error("debug enable level wrong");

  // Main scenarios reached
  c_por_end: cover property ($rose(POWER_ON_RESET_N));
  c_cfg_drive: cover property ($rose(CONFIG_DATA_OE));
  c_debug: cover property ($rose(DEBUG_PINS_OE));
  c_nmi: cover property (IRQ_LINE0_N_OE && NMI_SEEN);
endmodule // brc_reset_config_sva

bind brc_reset_config brc_reset_config_sva #(.POR_CYCLES(POR_CYCLES), .CS_REGIONS(CS_REGIONS)) i_sva
(
  .CLOCK, .RESET, .POWER_ON_RESET_N, .CLOCK_MODE_PINS, .CLOCK_MODE_OE, .HARD_RESET_N_OUT,
  .HARD_RESET_N_OE, .SOFT_RESET_N_OUT, .SOFT_RESET_N_OE, .RESET_CONFIG_SELECT_N, .CONFIG_WORD,
  .CONFIG_DATA, .CONFIG_DATA_OE, .DEBUG_MODE_ENABLE, .DEBUG_SERIAL_CLOCK, .DEBUG_PINS_OE,
  .IRQ_LINE0_N_OUT, .IRQ_LINE0_N_OE, .NMI_SEEN, .REGION_ENABLE, .CHIP_SELECT_N, .TRANSCEIVER_ENABLE
);

// ==== tb/brc_cpu_model.sv ====
// Processor side model: shared lines, internal reset source, config sampling
`timescale 1ns/1ns
module brc_cpu_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Board pulls and requests to the processor side
  input  wire logic        hard_oe,
  input  wire logic        soft_oe,
  input  wire logic        irq_oe,
  input  wire logic        int_hard,
  input  wire logic        ext_nmi,
  // Configuration pins
  input  wire logic        por_n,
  input  wire logic [1:0]  mode_pins,
  input  wire logic        mode_oe,
  input  wire logic        cfg_sel_n,
  input  wire logic [15:0] cfg_data,
  input  wire logic        cfg_oe,
  // Resolved lines and what was sampled
  output logic             hard_n,
  output logic             soft_n,
  output logic             irq_n,
  output logic [15:0]      cfg_seen,
  output logic [1:0]       mode_seen
);
  int unsigned pull;
  logic        hard_q;

  // Wired-AND of all pull-downs, pulled up when idle
  assign hard_n = !(hard_oe || pull != 0);
  assign soft_n = !soft_oe;
  assign irq_n  = !(irq_oe || ext_nmi);

  // Internal source holds the line its minimum time
  always_ff @(posedge clk)
  begin
    pull   <= reset ? 0 : int_hard ? 512 : (pull != 0) ? pull - 1 : 0;
    hard_q <= hard_n;
  end

  // Mode pins taken while power-on stands, data at hard release; undriven reads inverted
  always_ff @(posedge clk)
  begin
    if (hard_n && !hard_q)
      cfg_seen <= (cfg_oe && !cfg_sel_n) ? cfg_data : ~cfg_data;
    if (!por_n)
      mode_seen <= mode_oe ? mode_pins : ~mode_pins;
  end
endmodule // brc_cpu_model

// ==== tb/brc_reset_config_tb.sv ====
// Self-checking bench for the reset and configuration block
`timescale 1ns/1ns
module brc_reset_config_tb;
  localparam int unsigned POR = 50;
  logic        clock = 0, reset = 1, vlow_n = 1, serial = 0, db3 = 0, init_n = 1;
  logic        dbg_en = 1, dbg_entry = 0, dbg_ck = 1, cfg_wr = 0, int_hard = 0, ext_nmi = 0;
  logic [2:0]  btn_n = 3'h7;
  logic [15:0] cfg_wd = 16'h0000;
  logic [7:0]  region = 8'hFF, cs_n = 8'hFF;
  wire         por_n, mode_oe, hard_out, hard_oe, soft_out, soft_oe, cfg_sel_n, cfg_oe;
  wire         debug_serial_clock, debug_serial_data_in, dbg_oe, irq_out, irq_oe, nmi, xcvr, hard_n, soft_n, irq_n;
  wire  [1:0]  mode_pins, mode_seen;
  wire  [15:0] cfg_word, cfg_data, cfg_seen;
  int          mismatches = 0, checks_done = 0, cycles = 0, n;

  // Clock of 8 ns
  initial
  begin
    forever #4 clock = ~clock;
  end

  brc_reset_config #(.POR_CYCLES(POR), .DEBOUNCE_CYCLES(4), .CS_REGIONS(8)) i_dut
  (
    .CLOCK(clock), .RESET(reset), .VOLTAGE_LOW_N(vlow_n), .POWER_ON_BUTTON_N(btn_n[2]),
    .SOFT_RESET_BUTTON_N(btn_n[1]), .ABORT_BUTTON_N(btn_n[0]), .HOST_SERIAL_MODE(serial),
    .PARALLEL_DATA_BIT3(db3), .PARALLEL_INIT_N(init_n), .DEBUG_MODE_ENABLE(dbg_en),
    .DEBUG_MODE_ENTRY(dbg_entry), .DEBUG_CLOCK_MODE(dbg_ck), .CONFIG_WRITE(cfg_wr),
    .CONFIG_WRITE_DATA(cfg_wd), .CONFIG_WORD(cfg_word), .REGION_ENABLE(region), .CHIP_SELECT_N(cs_n),
    .POWER_ON_RESET_N(por_n), .CLOCK_MODE_PINS(mode_pins), .CLOCK_MODE_OE(mode_oe),
    .HARD_RESET_N_IN(hard_n), .HARD_RESET_N_OUT(hard_out), .HARD_RESET_N_OE(hard_oe),
    .SOFT_RESET_N_IN(soft_n), .SOFT_RESET_N_OUT(soft_out), .SOFT_RESET_N_OE(soft_oe),
    .RESET_CONFIG_SELECT_N(cfg_sel_n), .CONFIG_DATA(cfg_data), .CONFIG_DATA_OE(cfg_oe),
    .DEBUG_SERIAL_CLOCK(debug_serial_clock), .DEBUG_SERIAL_DATA_IN(debug_serial_data_in), .DEBUG_PINS_OE(dbg_oe),
    .IRQ_LINE0_N_IN(irq_n), .IRQ_LINE0_N_OUT(irq_out), .IRQ_LINE0_N_OE(irq_oe), .NMI_SEEN(nmi),
    .TRANSCEIVER_ENABLE(xcvr)
  );

  brc_cpu_model i_cpu
  (
    .clk(clock), .reset(reset), .hard_oe(hard_oe), .soft_oe(soft_oe), .irq_oe(irq_oe),
    .int_hard(int_hard), .ext_nmi(ext_nmi), .por_n(por_n), .mode_pins(mode_pins), .mode_oe(mode_oe),
    .cfg_sel_n(cfg_sel_n), .cfg_data(cfg_data), .cfg_oe(cfg_oe), .hard_n(hard_n), .soft_n(soft_n),
    .irq_n(irq_n), .cfg_seen(cfg_seen), .mode_seen(mode_seen)
  );

  task test_done;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Sample a little after the edge so its updates have landed
  task tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  // Wait for all reset lines free, then let the debug window close
  task settle;
    for (n = 0; n < 3000 && !(hard_n && soft_n && por_n); n++)
      tick(1);
    tick(140);
  endtask

  task t_power_sources;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      if (i == 0)
        vlow_n <= 1'b0;
      else
        btn_n <= 3'h3;
      tick(12);
      chk("power on reset", por_n, 0);
      chk("clock mode", {mode_oe, mode_pins}, 3'h6);
      @(posedge clock);
      vlow_n <= 1'b1;
      btn_n  <= 3'h7;
      tick(POR - 5);
      chk("reset stretch", por_n, 0);
      settle;
      chk("mode sampled", mode_seen, 2'h2);
    end
  endtask

  task t_soft_debug;
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_wd <= 16'hA5C3;
    @(posedge clock);
    cfg_wr <= 1'b0;
    btn_n  <= 3'h5;
    tick(14);
    chk("config word", cfg_word, 16'hA5C3);
    chk("soft only", {soft_oe, hard_oe}, 2'h2);
    chk("debug enable", {dbg_oe, debug_serial_clock}, 2'h3);
    @(posedge clock);
    btn_n <= 3'h7;
    for (n = 0; n < 1000 && !soft_n; n++)
      tick(1);
    tick(5);
    chk("debug after", {dbg_oe, debug_serial_clock, debug_serial_data_in}, 3'h5);
    settle;
  endtask

  task t_hard_buttons;
    @(posedge clock);
    btn_n <= 3'h4;
    tick(14);
    chk("hard not nmi", {hard_oe, irq_oe, cfg_sel_n}, 3'h4);
    chk("config drive", {cfg_oe, xcvr}, 2'h3);
    chk("config data", cfg_data, 16'hA5C3);
    @(posedge clock);
    btn_n <= 3'h7;
    settle;
    chk("config sampled", cfg_seen, 16'hA5C3);
  endtask

  task t_host;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      serial <= (i == 0);
      db3    <= (i == 0);
      init_n <= (i == 0);
      tick(6);
      chk("host reset", hard_oe, 1);
      @(posedge clock);
      db3    <= 1'b0;
      init_n <= 1'b1;
      settle;
    end
  endtask

  task t_internal;
    @(posedge clock);
    int_hard <= 1'b1;
    @(posedge clock);
    int_hard <= 1'b0;
    tick(5);
    chk("internal select", cfg_sel_n, 0);
    settle;
    chk("internal config", cfg_seen, 16'hA5C3);
  endtask

  task t_nmi;
    @(posedge clock);
    btn_n <= 3'h6;
    @(posedge clock);
    btn_n <= 3'h7;
    for (n = 0; n < 10; n++)
    begin
      tick(1);
      chk("glitch ignored", irq_oe, 0);
    end
    @(posedge clock);
    btn_n <= 3'h6;
    tick(14);
    chk("abort nmi", {irq_oe, nmi}, 2'h3);
    @(posedge clock);
    btn_n <= 3'h7;
    tick(14);
    @(posedge clock);
    ext_nmi <= 1'b1;
    tick(4);
    chk("external nmi", {irq_oe, nmi}, 2'h1);
    @(posedge clock);
    ext_nmi <= 1'b0;
  endtask

  task t_xcvr;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock);
      region <= i[0] ? 8'hFF : ~(8'h01 << i[3:1]);
      cs_n   <= ~(8'h01 << i[3:1]);
      tick(4);
      chk("transceiver", xcvr, i[0]);
    end
  endtask

  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      test_done;
    end
  end

  initial
  begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    tick(2);
    chk("reset por", por_n, 0);
    chk("default word", cfg_word, 16'h1002);
    settle;
    chk("default sampled", cfg_seen, 16'h1002);
    t_power_sources;
    t_soft_debug;
    t_hard_buttons;
    t_host;
    t_internal;
    t_nmi;
    t_xcvr;
    test_done;
  end
endmodule // brc_reset_config_tb
